// ==== rtl/bus_agent_cycle.sv ====
// Cycle sequencer and address space decoder for one system bus agent.
// Assumes bus lines are already synchronous and open-drain lines resolved outside.
`timescale 1ns/100ps
`default_nettype none
module bus_agent_cycle #(
  parameter int RES_LEN = bus_agent_pkg::RES_CYCLES
) (
  input  wire logic                                clk_i,
  input  wire logic                                rst_i,
  input  wire logic                                local_req_i,
  input  wire logic                                local_last_i,
  input  wire logic                                local_is_io_i,
  input  wire logic [bus_agent_pkg::ADDR_W-1:0]    local_addr_i,
  input  wire logic                                parity_err_i,
  input  wire logic                                reply_ack_i,
  input  wire logic                                shared_bus_request_line_i,
  output logic                                     shared_bus_request_line_o,
  output logic                                     shared_bus_request_line_oe_o,
  input  wire logic [bus_agent_pkg::ARB_W-1:0]     arbitration_id_lines_i,
  output logic [bus_agent_pkg::ARB_W-1:0]          arbitration_id_lines_o,
  output logic                                     arbitration_id_lines_oe_o,
  input  wire logic                                parity_fault_line_i,
  output logic                                     parity_fault_line_o,
  output logic                                     parity_fault_line_oe_o,
  input  wire logic                                cycle_timeout_line_i,
  output logic                                     grant_o,
  output logic                                     req_phase_o,
  output logic                                     data_strobe_o,
  output logic                                     end_cycle_o,
  output logic                                     aborted_o,
  output logic [bus_agent_pkg::SPACE_W-1:0]        space_o,
  output logic                                     cs_mem_o,
  output logic                                     cs_io_o,
  output logic                                     cs_msg_o,
  output logic                                     cs_ics_o,
  output logic [bus_agent_pkg::MSG_ADDR_W-1:0]     msg_addr_o,
  output logic [bus_agent_pkg::ARB_W-1:0]          slot_id_o,
  output logic [bus_agent_pkg::ARB_W-1:0]          arb_id_o
);
  import bus_agent_pkg::*;

  initial begin
    if (RES_LEN < 1 || RES_LEN > 255) $error("RES_LEN out of range");
    if (SLOT_POS + ARB_W > ADDR_W) $error("slot field outside address");
  end

  // ==========================================================
  // Address space decode
  cyc_state_e           state_reg;
  cyc_state_e           state_next;
  logic [7:0]           res_cnt_reg;
  logic                 id_taken_reg;
  logic                 in_reset_reg;
  logic [ARB_W-1:0]     slot_reg;
  logic [ARB_W-1:0]     arbid_reg;
  logic [SPACE_W-1:0]   space_reg;
  logic                 cs_mem_reg;
  logic                 cs_io_reg;
  logic                 cs_msg_reg;
  logic                 cs_ics_reg;
  logic [MSG_ADDR_W-1:0] msg_addr_reg;
  logic                 abort_reg;
  logic                 fault_reg;

  // Message and interconnect windows are carved from local memory space
  wire logic       hit_msg  = !local_is_io_i &&
                              (local_addr_i[31:28] == MSG_BASE[31:28]) &&
                              (local_addr_i[7:0] <= MSG_ADDR_MAX);
  wire logic       hit_ics  = !local_is_io_i &&
                              (local_addr_i[31:28] == ICS_BASE[31:28]);
  wire logic [1:0] dec_space = hit_msg ? SPACE_MSG :
                               hit_ics ? SPACE_ICS :
                               local_is_io_i ? SPACE_IO : SPACE_MEM;
  // Geographic select: slot field compared with the slot caught on the first edge after reset release
  wire logic       ics_mine = hit_ics &&
                    (local_addr_i[SLOT_POS +: ARB_W] == slot_reg);

  // ==========================================================
  // Exception and arbitration conditions
  wire logic exc_seen  = parity_fault_line_i || cycle_timeout_line_i || parity_err_i;
  wire logic exc_lines = parity_fault_line_i || cycle_timeout_line_i;
  // Highest priority: lines resolve to our own id (wired-or of contenders)
  // Our own drive must show on the shared line before acquisition counts
  wire logic line_busy = shared_bus_request_line_i;
  wire logic we_win    = line_busy && (arbitration_id_lines_i == arbid_reg);
  wire logic res_done  = (res_cnt_reg == 8'(RES_LEN - 1));

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:    if (local_req_i && id_taken_reg) state_next = ST_RESOLVE;
      ST_RESOLVE: if (exc_seen) state_next = ST_SIGNAL;
                  else if (res_done) state_next = ST_ACQUIRE;
      ST_ACQUIRE: if (exc_seen) state_next = ST_SIGNAL;
                  else if (we_win) state_next = ST_REQUEST;
                  else state_next = ST_RESOLVE;
      ST_REQUEST: if (exc_seen) state_next = ST_SIGNAL;
                  else state_next = ST_REPLY;
      ST_REPLY:   if (exc_seen) state_next = ST_SIGNAL;
                  else if (reply_ack_i && local_last_i) state_next = ST_IDLE;
      ST_SIGNAL:  state_next = ST_RECOVER;
      // Wait for every exception line to drop before reopening arbitration
      ST_RECOVER: if (!exc_lines) state_next = ST_IDLE;
      default:    state_next = ST_IDLE;
    endcase
    if (!exc_seen && state_reg == ST_IDLE && exc_lines) state_next = ST_IDLE;
  end

  // ==========================================================
  // Next-value decode for the sequencer registers
  wire logic       in_resolve   = (state_reg == ST_RESOLVE);
  wire logic       in_transfer  = (state_reg == ST_REQUEST) || (state_reg == ST_REPLY);
  wire logic [7:0] res_cnt_next = (in_resolve && !res_done) ? res_cnt_reg + 8'h01 : 8'h00;
  // Abort flag is registered from the next state, so it rises together with the signal phase entry
  wire logic       abort_next   = (state_next == ST_SIGNAL);
  // Only a local parity error while we own the bus raises the fault line
  wire logic       fault_next   = parity_err_i && in_transfer;

  // ==========================================================
  // Sequencer registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg   <= ST_IDLE;
      res_cnt_reg <= 8'h00;
    end else begin
      state_reg   <= state_next;
      res_cnt_reg <= res_cnt_next;
    end
  end

  // Reset bookkeeping: id capture edge first, requests after it
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      in_reset_reg <= 1'b1;
      id_taken_reg <= 1'b0;
    end else begin
      in_reset_reg <= 1'b0;
      id_taken_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      abort_reg <= 1'b0;
      fault_reg <= 1'b0;
    end else begin
      abort_reg <= abort_next;
      fault_reg <= fault_next;
    end
  end

  // Ids are caught on the first edge after reset release, never by the reset itself
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      slot_reg  <= '0;
      arbid_reg <= '0;
    end else if (in_reset_reg) begin
      slot_reg  <= arbitration_id_lines_i;
      arbid_reg <= arbitration_id_lines_i;
    end
  end

  // Selects only while a local access is pending
  wire logic cs_mem_next = local_req_i && (dec_space == SPACE_MEM);
  wire logic cs_io_next  = local_req_i && (dec_space == SPACE_IO);
  wire logic cs_msg_next = local_req_i && hit_msg;
  wire logic cs_ics_next = local_req_i && ics_mine;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      space_reg    <= SPACE_MEM;
      msg_addr_reg <= '0;
    end else begin
      space_reg    <= dec_space;
      msg_addr_reg <= local_addr_i[MSG_ADDR_W-1:0];
    end
  end

  // ==========================================================
  // Chip select registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cs_mem_reg <= 1'b0;
      cs_io_reg  <= 1'b0;
      cs_msg_reg <= 1'b0;
      cs_ics_reg <= 1'b0;
    end else begin
      cs_mem_reg <= cs_mem_next;
      cs_io_reg  <= cs_io_next;
      cs_msg_reg <= cs_msg_next;
      cs_ics_reg <= cs_ics_next;
    end
  end

  // ==========================================================
  // Bus line drive
  wire logic arbitrating = (state_reg == ST_RESOLVE) || (state_reg == ST_ACQUIRE);
  assign shared_bus_request_line_o    = arbitrating;
  assign shared_bus_request_line_oe_o = arbitrating;
  assign arbitration_id_lines_o       = arbitrating ? arbid_reg : '0;
  assign arbitration_id_lines_oe_o    = arbitrating;
  assign parity_fault_line_o          = fault_reg;
  assign parity_fault_line_oe_o       = fault_reg;

  assign grant_o       = (state_reg == ST_REQUEST) || (state_reg == ST_REPLY);
  assign req_phase_o   = (state_reg == ST_REQUEST);
  assign data_strobe_o = (state_reg == ST_REPLY) && reply_ack_i && !exc_seen;
  assign end_cycle_o   = (state_reg == ST_REPLY) && reply_ack_i && local_last_i && !exc_seen;
  assign aborted_o     = abort_reg;
  assign space_o       = space_reg;
  assign cs_mem_o      = cs_mem_reg;
  assign cs_io_o       = cs_io_reg;
  assign cs_msg_o      = cs_msg_reg;
  assign cs_ics_o      = cs_ics_reg;
  assign msg_addr_o    = msg_addr_reg;
  assign slot_id_o     = slot_reg;
  assign arb_id_o      = arbid_reg;

endmodule
`default_nettype wire

// ==== rtl/bus_agent_pkg.sv ====
// Constants and types for the system bus agent cycle controller.
// Assumes one system bus clock shared by all agents and an active-high reset.
//
// Function
// - Agent supports four address spaces: memory, I/O, message, interconnect.
// - Message space offers 255 distinct addresses for block exchange.
// - Interconnect space selects an agent by its slot number.
// - Message and interconnect spaces map into local memory space only, with chip selects.
// - Arbitration runs resolution first, then acquisition.
// - Only the highest priority contender starts a transfer in acquisition.
// - Transfer starts with owner request phase, then handshaked reply phase.
// - Reply phase repeats per handshake until the owner ends the cycle.
// - Any exception signal makes every agent abort arbitration or transfer.
// - Signal phase is followed by recovery while exception lines go inactive.
// - New arbitration only from the clock after recovery ends.
// - Arbitration id lines carry our id in arbitration, read at reset.
// - Agent drives shared request line and samples it for contention.
// - Parity error during transfer drives the parity fault line.
`default_nettype none
package bus_agent_pkg;

  localparam int ARB_W       = 5;
  localparam int ADDR_W      = 32;
  localparam int SPACE_W     = 2;
  localparam int MSG_ADDR_W  = 8;
  localparam logic [MSG_ADDR_W-1:0] MSG_ADDR_MAX = 8'hFE;
  localparam int RES_CYCLES  = 2;
  localparam int SLOT_POS    = 24;
  localparam logic [ADDR_W-1:0] MSG_BASE = 32'hF000_0000;
  localparam logic [ADDR_W-1:0] ICS_BASE = 32'hE000_0000;
  localparam logic [3:0] WIN_MASK_HI = 4'hF;

  typedef enum logic [1:0] {
    SPACE_MEM = 2'b00,
    SPACE_IO  = 2'b01,
    SPACE_MSG = 2'b10,
    SPACE_ICS = 2'b11
  } space_e;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_RESOLVE = 3'b001,
    ST_ACQUIRE = 3'b010,
    ST_REQUEST = 3'b011,
    ST_REPLY   = 3'b100,
    ST_SIGNAL  = 3'b101,
    ST_RECOVER = 3'b110
  } cyc_state_e;

endpackage
`default_nettype wire

// ==== tb/bus_agent_cycle_monitor.sv ====
// Port checker for the agent cycle controller.
// Assumes one clock domain; bound into every controller instance.
`timescale 1ns/100ps
`default_nettype none
module bus_agent_cycle_monitor
  import bus_agent_pkg::*;
(
  input wire logic               clk_i,
  input wire logic               rst_i,
  input wire logic               local_last_i,
  input wire logic               parity_err_i,
  input wire logic               reply_ack_i,
  input wire logic               cycle_timeout_line_i,
  input wire logic               shared_bus_request_line_oe_o,
  input wire logic [ARB_W-1:0]   arbitration_id_lines_o,
  input wire logic               arbitration_id_lines_oe_o,
  input wire logic               parity_fault_line_o,
  input wire logic               parity_fault_line_oe_o,
  input wire logic               grant_o,
  input wire logic               req_phase_o,
  input wire logic               data_strobe_o,
  input wire logic               end_cycle_o,
  input wire logic               aborted_o,
  input wire logic [SPACE_W-1:0] space_o,
  input wire logic               cs_msg_o,
  input wire logic [ARB_W-1:0]   arb_id_o
);
  // ========
  // Properties
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    req_phase_o ##1 !req_phase_o;
  endsequence
  sequence s_abort;
    ##[1:2] aborted_o ##0 !grant_o;
  endsequence
  AST_ARB_LINES: assert property (shared_bus_request_line_oe_o == arbitration_id_lines_oe_o)
    else $error("request and id enables differ");
  AST_OWN_ID: assert property (arbitration_id_lines_oe_o |-> arbitration_id_lines_o == arb_id_o)
    else $error("wrong id driven");
  AST_GRANT_QUIET: assert property (grant_o |-> !shared_bus_request_line_oe_o)
    else $error("arbitrating while owner");
  AST_REQ_FIRST: assert property ($rose(grant_o) |-> s_req)
    else $error("no single request phase");
  AST_STROBE: assert property (data_strobe_o |-> grant_o && !req_phase_o && reply_ack_i)
    else $error("strobe without handshake");
  AST_END: assert property (end_cycle_o |-> data_strobe_o && local_last_i ##1 !grant_o)
    else $error("bad cycle end");
  AST_ABORT: assert property (grant_o && cycle_timeout_line_i |-> s_abort)
    else $error("no abort on exception");
  AST_FAULT: assert property (grant_o && parity_err_i |=> parity_fault_line_oe_o && parity_fault_line_o)
    else $error("parity fault not driven");
  AST_REARB: assert property ($fell(cycle_timeout_line_i) |-> !shared_bus_request_line_oe_o [*2])
    else $error("arbitration too early");
  AST_MSG_CS: assert property (cs_msg_o |-> space_o == SPACE_MSG)
    else $error("message select mismatch");
endmodule
bind bus_agent_cycle bus_agent_cycle_monitor u_bus_agent_cycle_monitor (.clk_i, .rst_i,
  .local_last_i, .parity_err_i, .reply_ack_i, .cycle_timeout_line_i,
  .shared_bus_request_line_oe_o, .arbitration_id_lines_o, .arbitration_id_lines_oe_o,
  .parity_fault_line_o, .parity_fault_line_oe_o, .grant_o, .req_phase_o, .data_strobe_o,
  .end_cycle_o, .aborted_o, .space_o, .cs_msg_o, .arb_id_o);
`default_nettype wire

// ==== tb/bus_agent_partner.sv ====
// Replier and central services seen from one agent.
// Assumes the design's id drive and grant as inputs.
`timescale 1ns/100ps
`default_nettype none
module bus_agent_partner
  import bus_agent_pkg::*;
#(
  parameter logic [ARB_W-1:0] INIT_ID = 5'h0A
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             grant_i,
  input  wire logic             rival_i,
  input  wire logic [1:0]       dly_i,
  input  wire logic [ARB_W-1:0] id_i,
  input  wire logic             id_oe_i,
  output logic      [ARB_W-1:0] ids_o,
  output var logic              ack_o
);
  // ========
  // Model
  logic       init_reg;
  logic [1:0] wait_reg;
  // Released lines show the inverse, never a stale copy
  assign ids_o = init_reg ? INIT_ID : !id_oe_i ? ~id_i : rival_i ? id_i ^ 5'h10 : id_i;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      init_reg <= 1'h1;
      wait_reg <= 2'h0;
      ack_o    <= 1'h0;
    end else begin
      init_reg <= 1'h0;
      if (!grant_i || ack_o) begin
        ack_o    <= 1'h0;
        wait_reg <= 2'h0;
      end else if (wait_reg == dly_i) ack_o <= 1'h1;
      else wait_reg <= wait_reg + 2'h1;
    end
  end
endmodule
`default_nettype wire

// ==== tb/system_bus_agent_cycle_control_tb.sv ====
// Self-checking bench for the agent cycle controller.
// Assumes the partner model answers handshakes and hands out ids.
`timescale 1ns/100ps
`default_nettype none
module system_bus_agent_cycle_control_tb;
  import bus_agent_pkg::*;
  // ========
  // Stimulus
  localparam logic [ARB_W-1:0] ID = 5'h0A;
  logic clk_i = 0, rst_i = 1, req = 0, last = 0, io = 0, perr = 0, tmo = 0, rival = 0;
  logic [31:0] addr = '0, r;
  logic [1:0] dly = '0;
  logic ack, rq_o, rq_oe, id_oe, f_o, f_oe, grant, rph, strb, endc, abt, cm, ci, cg, cx;
  logic [4:0] ids, id_o, slot, arb;
  logic [1:0] sp;
  logic [7:0] ma;
  int err_count = 0, cmp_count = 0, seed = 32'hF859, n, k, j;
  always #5 clk_i = ~clk_i;
  bus_agent_cycle #(.RES_LEN(3)) u_bus_agent_cycle (.clk_i(clk_i), .rst_i(rst_i),
    .local_req_i(req), .local_last_i(last), .local_is_io_i(io), .local_addr_i(addr),
    .parity_err_i(perr), .reply_ack_i(ack), .shared_bus_request_line_i(rq_oe & rq_o | rival),
    .shared_bus_request_line_o(rq_o), .shared_bus_request_line_oe_o(rq_oe),
    .arbitration_id_lines_i(ids), .arbitration_id_lines_o(id_o), .arbitration_id_lines_oe_o(id_oe),
    .parity_fault_line_i(f_oe & f_o), .parity_fault_line_o(f_o), .parity_fault_line_oe_o(f_oe),
    .cycle_timeout_line_i(tmo), .grant_o(grant), .req_phase_o(rph), .data_strobe_o(strb),
    .end_cycle_o(endc), .aborted_o(abt), .space_o(sp), .cs_mem_o(cm), .cs_io_o(ci),
    .cs_msg_o(cg), .cs_ics_o(cx), .msg_addr_o(ma), .slot_id_o(slot), .arb_id_o(arb));
  bus_agent_partner #(.INIT_ID(ID)) u_bus_agent_partner (.clk_i(clk_i), .rst_i(rst_i),
    .grant_i(grant), .rival_i(rival), .dly_i(dly), .id_i(id_o), .id_oe_i(id_oe),
    .ids_o(ids), .ack_o(ack));
  function automatic space_e exp_sp(input logic [31:0] a, input logic i);
    if (a[31:28] == 4'hF) return SPACE_MSG;
    if (a[31:28] == 4'hE && a[28:24] == ID) return SPACE_ICS;
    return i ? SPACE_IO : SPACE_MEM;
  endfunction
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_sig(ref logic s);
    for (j = 0; j < 60 && s !== 1'h1; j++) @(negedge clk_i);
    if (s !== 1'h1) begin
      err_count++;
      final_report();
    end
  endtask
  // Exception codes: 0 none, 1 timeout, 2 parity; request held through recovery
  task automatic access(input logic [31:0] a, input logic i, input int cnt, exc, rv);
    addr = a; io = i; req = 1; rival = rv; dly = 2'($random(seed)); n = 0;
    @(negedge clk_i);
    chk(sp, exp_sp(a, i));
    chk({cx, cg, ci, cm}, 4'h1 << exp_sp(a, i));
    if (exp_sp(a, i) == SPACE_MSG) chk(ma, a[7:0]);
    if (rv) begin
      repeat (12) @(negedge clk_i);
      chk(grant, 0);
      rival = 0;
    end
    wait_sig(grant);
    if (exc != 0) begin
      @(negedge clk_i);
      if (exc == 1) tmo = 1; else perr = 1;
      @(negedge clk_i);
      perr = 0;
      if (exc == 2) chk(f_oe & f_o, 1);
      wait_sig(abt);
      // Parity fault line drops by itself, so recovery is short there
      repeat ((exc == 1) ? 3 : 1) @(negedge clk_i);
      tmo = 0;
      chk(grant | rq_oe, 0);
      @(negedge clk_i);
      chk(rq_oe, 0);
      wait_sig(grant);
    end
    last = (cnt == 1);
    for (k = 0; k < 200 && n < cnt; k++) begin
      @(negedge clk_i);
      if (strb === 1'h1) begin
        n++;
        chk(endc, n == cnt);
      end
      last = (n >= cnt - 1);
    end
    chk(n, cnt);
    @(negedge clk_i);
    chk(grant, 0);
    req = 0;
    last = 0;
  endtask
  initial begin
    repeat (4) @(negedge clk_i);
    rst_i = 0;
    repeat (2) @(negedge clk_i);
    chk(slot, ID);
    chk(arb, ID);
    access(32'hF000_00FE, 0, 1, 0, 1);
    access(32'hEA00_0000, 0, 3, 1, 0);
    access(32'h0000_0040, 1, 2, 2, 0);
    for (int t = 0; t < 8; t++) begin
      r = $random(seed);
      case (r[1:0])
        2'h0: access({4'h1, r[31:4]}, 0, 1 + r[3:2], 0, 0);
        2'h1: access({4'h2, r[31:4]}, 1, 1 + r[3:2], 0, 0);
        2'h2: access({24'hF00000, (r[31:24] == 8'hFF) ? 8'hFE : r[31:24]}, 0, 1 + r[3:2], 0, 0);
        default: access({8'hEA, r[31:8]}, 0, 1 + r[3:2], 0, 0);
      endcase
    end
    final_report();
  end
endmodule
`default_nettype wire
